// ---- common/rct_pkg.sv ----
// Constants for the reload/capture timer: register offsets, field positions,
// reset values and divider counts.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Function
// - 16-bit mode with capture off reloads on FFFF wrap, sets high flag
// - Full overflow interrupts when timer interrupt enabled and capture off
// - Low-byte wrap interrupts too when low enable set
// - Split mode: two 8-bit reload timers
// - Split: run gates high byte only
// - Per-byte clock choose, shared alternate selector
// - Comparator and external clock synchronized first
// - Split: each byte wrap sets own flag
// - Split: interrupt on high, or either with enable
// - Flags never cleared by hardware
// - Capture on comparator rise or eight external cycles
// - Capture copies count to reload, sets flag
package rct_pkg;

  // Register byte offsets (word aligned)
  localparam logic [4:0] OFS_CTRL   = 5'h00;  // Timer control register
  localparam logic [4:0] OFS_CLKSEL = 5'h04;  // Clock choice register
  localparam logic [4:0] OFS_RLL    = 5'h08;  // Reload low byte
  localparam logic [4:0] OFS_RLH    = 5'h0C;  // Reload high byte
  localparam logic [4:0] OFS_CNTL   = 5'h10;  // Count low byte
  localparam logic [4:0] OFS_CNTH   = 5'h14;  // Count high byte
  localparam logic [4:0] OFS_IRQEN  = 5'h18;  // Extended interrupt enable

  // Control register field positions
  localparam int CTRL_HI_FLAG = 7;
  localparam int CTRL_LO_FLAG = 6;
  localparam int CTRL_LO_IEN  = 5;
  localparam int CTRL_CAP_EN  = 4;
  localparam int CTRL_SPLIT   = 3;
  localparam int CTRL_RUN     = 2;
  localparam int CTRL_XCLK_HI = 1;
  localparam int CTRL_XCLK_LO = 0;

  // Clock choice register field positions
  localparam int CLK_HIGH_CHOOSE = 1;
  localparam int CLK_LOW_CHOOSE  = 0;

  // Interrupt enable register field position
  localparam int IRQEN_TIMER = 0;

  // Alternate selector encodings
  localparam logic [1:0] XCLK_DIV12 = 2'h0;
  localparam logic [1:0] XCLK_COMP  = 2'h1;
  localparam logic [1:0] XCLK_RSVD  = 2'h2;
  localparam logic [1:0] XCLK_EXT8  = 2'h3;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Divider counts
  localparam int          CORE_DIV    = 12;      // Core clock divided by 12
  localparam logic [3:0]  CORE_DIV_LAST = 4'hB;  // Last divider state
  localparam logic [2:0]  EXT_DIV_LAST  = 3'h7;  // Eighth external edge

  // Wrap values
  localparam logic [7:0]  BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;

endpackage

// ---- design/rct_timer.sv ----
// Reload/capture timer with a classic Wishbone register slave.
// Assumes comparator_i and ext_osc_i are synchronous-safe level inputs that
// are resynchronized here; one clock clk_i, synchronous active-high reset.
`timescale 1ns/1ps
module rct_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        comparator_i,
  input  wire logic        ext_osc_i,
  output logic             irq_o
);

  // Byte at its top value, used for both byte timers
  function automatic logic at_max(input logic [7:0] v);
    return v == rct_pkg::BYTE_MAX;
  endfunction

  // Alternate clock source pick, shared by both bytes
  function automatic logic alt_pick(input logic [1:0] sel, input logic d12,
                                    input logic cmp, input logic e8);
    unique case (sel)
      rct_pkg::XCLK_DIV12: return d12;
      rct_pkg::XCLK_COMP:  return cmp;
      rct_pkg::XCLK_EXT8:  return e8;
      default:             return 1'b0;  // Reserved code never ticks
    endcase
  endfunction

  // Software-visible state
  logic       hi_flag;          // High overflow flag
  logic       lo_flag;          // Low overflow flag
  logic       low_byte_irq_enable;
  logic       capture_enable;
  logic       split_mode_select;
  logic       run_control;
  logic [1:0] alternate_clock_selector;
  logic       high_byte_clock_choose;
  logic       low_byte_clock_choose;
  logic       timer_irq_enable; // Timer bit of extended enable register
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;

  // Synchronizers and dividers
  logic       comp_s1;          // First stage, read only by comp_s2
  logic       comp_s2;
  logic       comp_s3;          // Delayed copy for edge detect
  logic       ext_s1;           // First stage, read only by ext_s2
  logic       ext_s2;
  logic       ext_s3;
  logic [2:0] ext_cnt;          // External edge counter
  logic [3:0] div12_cnt;        // Core clock divider

  // Ticks and strobes
  logic       comp_rise;
  logic       ext_rise;
  logic       ext8_tick;
  logic       div12_tick;
  logic       alt_tick;
  logic       low_tick;
  logic       high_tick;
  logic       cap_evt;
  logic       bus_req;
  logic       wr;
  logic [15:0] count_word;

  assign bus_req    = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr         = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign count_word = {count_high_byte, count_low_byte};

  // Resynchronize the asynchronous sources before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
      comp_s3 <= 1'b0;
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
    end else begin
      comp_s1 <= comparator_i;
      comp_s2 <= comp_s1;
      comp_s3 <= comp_s2;
      ext_s1  <= ext_osc_i;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
    end
  end

  assign comp_rise = comp_s2 & ~comp_s3;
  assign ext_rise  = ext_s2 & ~ext_s3;
  assign ext8_tick = ext_rise & (ext_cnt == rct_pkg::EXT_DIV_LAST);
  assign div12_tick = (div12_cnt == rct_pkg::CORE_DIV_LAST);

  // External clock divided by eight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_cnt <= 3'h0;
    end else if (ext_rise) begin
      ext_cnt <= ext_cnt + 3'h1;  // Wraps naturally after eight edges
    end
  end

  // Core clock divided by twelve, free running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div12_cnt <= 4'h0;
    end else if (div12_tick) begin
      div12_cnt <= 4'h0;
    end else begin
      div12_cnt <= div12_cnt + 4'h1;
    end
  end

  // Per-byte clock enables from the choose bits
  assign alt_tick  = alt_pick(alternate_clock_selector, div12_tick, comp_rise, ext8_tick);
  assign low_tick  = low_byte_clock_choose  ? 1'b1 : alt_tick;
  assign high_tick = high_byte_clock_choose ? 1'b1 : alt_tick;

  // Capture trigger: selector bit 1 picks external / 8, else comparator rise
  assign cap_evt = capture_enable &
                   (alternate_clock_selector[1] ? ext8_tick : comp_rise);

  // Control fields other than the flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_byte_irq_enable      <= 1'b0;
      capture_enable           <= 1'b0;
      split_mode_select        <= 1'b0;
      run_control              <= 1'b0;
      alternate_clock_selector <= rct_pkg::XCLK_DIV12;
      high_byte_clock_choose   <= 1'b0;
      low_byte_clock_choose    <= 1'b0;
      timer_irq_enable         <= 1'b0;
    end else if (wr) begin
      unique case (wb_adr_i)
        rct_pkg::OFS_CTRL: begin
          low_byte_irq_enable      <= wb_dat_i[rct_pkg::CTRL_LO_IEN];
          capture_enable           <= wb_dat_i[rct_pkg::CTRL_CAP_EN];
          split_mode_select        <= wb_dat_i[rct_pkg::CTRL_SPLIT];
          run_control              <= wb_dat_i[rct_pkg::CTRL_RUN];
          alternate_clock_selector <= wb_dat_i[rct_pkg::CTRL_XCLK_HI:rct_pkg::CTRL_XCLK_LO];
        end
        rct_pkg::OFS_CLKSEL: begin
          high_byte_clock_choose <= wb_dat_i[rct_pkg::CLK_HIGH_CHOOSE];
          low_byte_clock_choose  <= wb_dat_i[rct_pkg::CLK_LOW_CHOOSE];
        end
        rct_pkg::OFS_IRQEN: begin
          timer_irq_enable <= wb_dat_i[rct_pkg::IRQEN_TIMER];
        end
        default: begin
          // Other offsets leave the control fields alone
        end
      endcase
    end
  end

  // Counter, reload and flag machinery
  logic [7:0] next_cnt_l;
  logic [7:0] next_cnt_h;
  logic [7:0] next_rl_l;
  logic [7:0] next_rl_h;
  logic       set_hi;
  logic       set_lo;
  logic       wr_ctrl;

  always_comb begin
    next_cnt_l = count_low_byte;
    next_cnt_h = count_high_byte;
    next_rl_l  = reload_low_byte;
    next_rl_h  = reload_high_byte;
    set_hi     = 1'b0;
    set_lo     = 1'b0;
    if (split_mode_select && !capture_enable) begin
      // Low byte runs without run control while split is on and capture is off
      if (low_tick) begin
        if (at_max(count_low_byte)) begin
          next_cnt_l = reload_low_byte;
          set_lo     = 1'b1;
        end else begin
          next_cnt_l = count_low_byte + 8'h01;
        end
      end
      // High byte gated by run control
      if (run_control && high_tick) begin
        if (at_max(count_high_byte)) begin
          next_cnt_h = reload_high_byte;
          set_hi     = 1'b1;
        end else begin
          next_cnt_h = count_high_byte + 8'h01;
        end
      end
    end else if (run_control && low_tick) begin
      // Full 16-bit count on the low-byte clock
      set_lo = at_max(count_low_byte);  // Low wrap flagged in any mode
      if (count_word == rct_pkg::WORD_MAX && !capture_enable) begin
        next_cnt_l = reload_low_byte;
        next_cnt_h = reload_high_byte;
        set_hi     = 1'b1;
      end else begin
        {next_cnt_h, next_cnt_l} = count_word + 16'h0001;
      end
    end
    // Software writes to the count win over counting
    if (wr && wb_adr_i == rct_pkg::OFS_CNTL) begin
      next_cnt_l = wb_dat_i[7:0];
    end
    if (wr && wb_adr_i == rct_pkg::OFS_CNTH) begin
      next_cnt_h = wb_dat_i[7:0];
    end
    if (wr && wb_adr_i == rct_pkg::OFS_RLL) begin
      next_rl_l = wb_dat_i[7:0];
    end
    if (wr && wb_adr_i == rct_pkg::OFS_RLH) begin
      next_rl_h = wb_dat_i[7:0];
    end
    // A capture beats a same-cycle reload write: the measurement matters
    if (cap_evt && !split_mode_select) begin
      next_rl_l = count_low_byte;
      next_rl_h = count_high_byte;
      set_hi    = 1'b1;
    end
  end

  assign wr_ctrl = wr && (wb_adr_i == rct_pkg::OFS_CTRL);

  // Count and reload storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_low_byte   <= rct_pkg::RST_BYTE;
      count_high_byte  <= rct_pkg::RST_BYTE;
      reload_low_byte  <= rct_pkg::RST_BYTE;
      reload_high_byte <= rct_pkg::RST_BYTE;
    end else begin
      count_low_byte   <= next_cnt_l;
      count_high_byte  <= next_cnt_h;
      reload_low_byte  <= next_rl_l;
      reload_high_byte <= next_rl_h;
    end
  end

  // Sticky flags: hardware only sets, a set beats a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_flag <= 1'b0;
      lo_flag <= 1'b0;
    end else begin
      hi_flag <= set_hi | (wr_ctrl ? wb_dat_i[rct_pkg::CTRL_HI_FLAG] : hi_flag);
      lo_flag <= set_lo | (wr_ctrl ? wb_dat_i[rct_pkg::CTRL_LO_FLAG] : lo_flag);
    end
  end

  // Interrupt request, level while a qualifying flag is up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= timer_irq_enable & (hi_flag | (low_byte_irq_enable & lo_flag));
    end
  end

  // Bus slave: one wait state, ack drops the cycle after it rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= rct_pkg::RST_WORD;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      unique case (wb_adr_i)
        rct_pkg::OFS_CTRL:   wb_dat_o <= {24'h00_0000, hi_flag, lo_flag,
                                          low_byte_irq_enable, capture_enable,
                                          split_mode_select, run_control,
                                          alternate_clock_selector};
        rct_pkg::OFS_CLKSEL: wb_dat_o <= {30'h0000_0000, high_byte_clock_choose,
                                          low_byte_clock_choose};
        rct_pkg::OFS_RLL:    wb_dat_o <= {24'h00_0000, reload_low_byte};
        rct_pkg::OFS_RLH:    wb_dat_o <= {24'h00_0000, reload_high_byte};
        rct_pkg::OFS_CNTL:   wb_dat_o <= {24'h00_0000, count_low_byte};
        rct_pkg::OFS_CNTH:   wb_dat_o <= {24'h00_0000, count_high_byte};
        rct_pkg::OFS_IRQEN:  wb_dat_o <= {31'h0000_0000, timer_irq_enable};
        default:             wb_dat_o <= rct_pkg::RST_WORD;  // Unmapped reads zero
      endcase
    end
  end

  // Checks on the counting, flag and interrupt behaviour
  logic quiet;  // No software write this cycle
  assign quiet = ~wr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RELOAD16: assert property (
    (!split_mode_select && !capture_enable && run_control && low_tick && quiet &&
     count_word == 16'hFFFF) |=> (count_word == $past({reload_high_byte, reload_low_byte})
                                  && hi_flag))
    else $error("16-bit wrap did not reload and flag");

  AST_IRQ_FULL: assert property (
    (timer_irq_enable && hi_flag) |=> irq_o)
    else $error("Full overflow did not interrupt");

  AST_IRQ_LOW: assert property (
    (timer_irq_enable && low_byte_irq_enable && lo_flag) |=> irq_o)
    else $error("Low-byte overflow did not interrupt");

  AST_SPLIT_LOW: assert property (
    (split_mode_select && !capture_enable && low_tick && quiet && at_max(count_low_byte))
    |=> (count_low_byte == $past(reload_low_byte) && lo_flag))
    else $error("Split low byte did not reload");

  AST_HIGH_HOLD: assert property (
    (split_mode_select && !capture_enable && !run_control && quiet)
    |=> $stable(count_high_byte))
    else $error("High byte moved without run control");

  AST_DIV12: assert property (
    div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
    else $error("Core divider not twelve cycles");

  AST_SYNC: assert property (
    comp_rise |-> ($past(comparator_i, 2) && !$past(comparator_i, 3)))
    else $error("Comparator edge not two-stage synchronized");

  AST_NO_IRQ: assert property (
    (!hi_flag && !lo_flag && !set_hi && !set_lo && quiet) |=> ##1 !irq_o)
    else $error("Interrupt without a flag");

  AST_STICKY: assert property (
    (hi_flag && lo_flag && !wr_ctrl) |=> (hi_flag && lo_flag))
    else $error("Flag cleared by hardware");

  AST_CAPTURE: assert property (
    (cap_evt && !split_mode_select)
    |=> ({reload_high_byte, reload_low_byte} == $past(count_word) && hi_flag))
    else $error("Capture did not copy count");

  AST_COUNT16: assert property (
    (!split_mode_select && run_control && low_tick && quiet && !at_max(count_low_byte))
    |=> count_word == $past(count_word) + 16'h0001)
    else $error("Full counter did not advance");

  COV_WRAP16: cover property (!split_mode_select && set_hi && !capture_enable);
  COV_SPLIT:  cover property (split_mode_select && set_lo ##[1:300] set_hi);
  COV_CAPT:   cover property (cap_evt ##[1:1000] cap_evt);

endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the reload/capture timer.
// Assumes the timer answers on classic Wishbone with one wait state.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic        clk_i        = 1'b0;           // Core clock
  logic        rst_i        = 1'b1;           // Synchronous reset
  logic        wb_cyc_i     = 1'b0;           // Bus cycle
  logic        wb_stb_i     = 1'b0;           // Bus strobe
  logic        wb_we_i      = 1'b0;           // Write select
  logic [4:0]  wb_adr_i     = 5'h00;          // Byte address
  logic [3:0]  wb_sel_i     = 4'h0;           // Byte enables
  logic [31:0] wb_dat_i     = 32'h0000_0000;  // Write data
  logic [31:0] wb_dat_o;                      // Read data
  logic        wb_ack_o;                      // Acknowledge
  logic        comparator_i = 1'b0;           // Comparator level
  logic        ext_osc_i    = 1'b0;           // External oscillator
  logic        irq_o;                         // Interrupt level
  int          miscompares  = 0;              // Mismatch count
  int          checks       = 0;              // Comparison count
  int          cycles       = 0;              // Hang guard
  logic [7:0]  d;                             // Read byte
  logic [15:0] cap_a;                         // First capture
  logic [15:0] cap_b;                         // Second capture

  rct_timer i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .comparator_i(comparator_i), .ext_osc_i(ext_osc_i), .irq_o(irq_o)
  );

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // Hang guard: generous for all scenarios together
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      $display("ERROR %0t: timeout", $time);
      miscompares++;
      wrap_up();
    end
  end

  // One classic cycle; released only after ack is seen, hang guard ends a stall
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h00_0000, v};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    d = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 8'h00);
  endtask

  // Bounded wait for the interrupt level
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_o !== lvl && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(irq_o, lvl)
  endtask

  // Reset state, unmapped place ignored
  task automatic t_reset();
    for (int a = 0; a < 32; a += 4) begin
      rd(a[4:0]);
      `CHK(d, 8'h00)
    end
    wr(5'h1C, 8'hAA);
    rd(5'h1C);
    `CHK(d, 8'h00)
    $display("test reset done");
  endtask

  // Full wrap reloads, flag stays until cleared
  task automatic t_reload();
    wr(rct_pkg::OFS_CLKSEL, 8'h01);
    wr(rct_pkg::OFS_RLL, 8'hF0);
    wr(rct_pkg::OFS_RLH, 8'hFE);
    wr(rct_pkg::OFS_CNTL, 8'hFA);
    wr(rct_pkg::OFS_CNTH, 8'hFF);
    wr(rct_pkg::OFS_IRQEN, 8'h01);
    wr(rct_pkg::OFS_CTRL, 8'h04);
    wait_irq(1'b1);
    wr(rct_pkg::OFS_CTRL, 8'h80);
    rd(rct_pkg::OFS_CNTH);
    `CHK(d, 8'hFE)
    rd(rct_pkg::OFS_CNTL);
    `CHK(d, 8'hF5)
    repeat (20) @(posedge clk_i);
    rd(rct_pkg::OFS_CTRL);
    `CHK(d, 8'h80)
    `CHK(irq_o, 1'b1)
    wr(rct_pkg::OFS_CTRL, 8'h00);
    wait_irq(1'b0);
    $display("test reload done");
  endtask

  // Low byte wrap interrupts only with its enable
  task automatic t_low_irq();
    wr(rct_pkg::OFS_RLL, 8'h00);
    wr(rct_pkg::OFS_RLH, 8'h00);
    wr(rct_pkg::OFS_CNTL, 8'hFD);
    wr(rct_pkg::OFS_CNTH, 8'h00);
    wr(rct_pkg::OFS_CTRL, 8'h04);
    repeat (20) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    rd(rct_pkg::OFS_CTRL);
    `CHK(d, 8'h44)
    wr(rct_pkg::OFS_CTRL, 8'h64);
    wait_irq(1'b1);
    wr(rct_pkg::OFS_CTRL, 8'h00);
    wait_irq(1'b0);
    $display("test low irq done");
  endtask

  // Two byte timers, run gates the high one only
  task automatic t_split();
    wr(rct_pkg::OFS_CLKSEL, 8'h03);
    wr(rct_pkg::OFS_RLL, 8'hF0);
    wr(rct_pkg::OFS_RLH, 8'h80);
    wr(rct_pkg::OFS_CNTL, 8'hFC);
    wr(rct_pkg::OFS_CNTH, 8'hFE);
    wr(rct_pkg::OFS_CTRL, 8'h08);
    repeat (20) @(posedge clk_i);
    rd(rct_pkg::OFS_CNTH);
    `CHK(d, 8'hFE)
    rd(rct_pkg::OFS_CTRL);
    `CHK(d, 8'h48)
    `CHK(irq_o, 1'b0)
    wr(rct_pkg::OFS_CTRL, 8'h0C);
    wait_irq(1'b1);
    rd(rct_pkg::OFS_CTRL);
    `CHK(d[7], 1'b1)
    wr(rct_pkg::OFS_CTRL, 8'h08);
    rd(rct_pkg::OFS_CNTH);
    `CHK(d[7:4], 4'h8)
    rd(rct_pkg::OFS_CNTL);
    `CHK(d[7:4], 4'hF)
    wr(rct_pkg::OFS_CTRL, 8'h28);
    wait_irq(1'b1);
    wr(rct_pkg::OFS_CTRL, 8'h00);
    $display("test split done");
  endtask

  // Every alternate source code, both slow inputs toggling together
  task automatic t_sources();
    logic [1:0] code [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    wr(rct_pkg::OFS_CLKSEL, 8'h00);
    foreach (code[k]) begin
      wr(rct_pkg::OFS_CTRL, 8'h00);
      wr(rct_pkg::OFS_CNTL, 8'h00);
      wr(rct_pkg::OFS_CNTH, 8'h00);
      wr(rct_pkg::OFS_CTRL, {6'h01, code[k]});
      for (int i = 0; i < 16; i++) begin
        @(posedge clk_i);
        comparator_i <= 1'b1;
        ext_osc_i    <= 1'b1;
        repeat (3) @(posedge clk_i);
        comparator_i <= 1'b0;
        ext_osc_i    <= 1'b0;
        repeat (2) @(posedge clk_i);
      end
      repeat (6) @(posedge clk_i);
      wr(rct_pkg::OFS_CTRL, 8'h00);
      rd(rct_pkg::OFS_CNTL);
      case (code[k])
        2'h1: `CHK(d, 8'h10)
        2'h2: `CHK(d, 8'h00)
        2'h3: `CHK(d, 8'h02)
        default: `CHK(d inside {[8'h07:8'h0A]}, 1'b1)
      endcase
    end
    $display("test sources done");
  endtask

  // Two comparator rises 100 cycles apart give a difference of 100
  task automatic t_capture();
    wr(rct_pkg::OFS_CLKSEL, 8'h01);
    wr(rct_pkg::OFS_CTRL, 8'h14);
    fork
      for (int i = 0; i < 2; i++) begin
        @(posedge clk_i);
        comparator_i <= 1'b1;
        repeat (50) @(posedge clk_i);
        comparator_i <= 1'b0;
        repeat (49) @(posedge clk_i);
      end
    join_none
    wait_irq(1'b1);
    rd(rct_pkg::OFS_RLL);
    cap_a[7:0] = d;
    rd(rct_pkg::OFS_RLH);
    cap_a[15:8] = d;
    wr(rct_pkg::OFS_CTRL, 8'h14);
    repeat (3) @(posedge clk_i);
    wait_irq(1'b1);
    rd(rct_pkg::OFS_RLL);
    cap_b[7:0] = d;
    rd(rct_pkg::OFS_RLH);
    cap_b[15:8] = d;
    `CHK(cap_b - cap_a, 16'h0064)
    rd(rct_pkg::OFS_CTRL);
    `CHK(d[7], 1'b1)
    // Selector bit 1 set: only every eighth external rise captures
    wr(rct_pkg::OFS_CTRL, 8'h16);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      ext_osc_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_osc_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      if (i < 7) `CHK(irq_o, 1'b0)
    end
    wait_irq(1'b1);
    wr(rct_pkg::OFS_CTRL, 8'h00);
    $display("test capture done");
  endtask

  // Closing report, the only exit
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_reload();
    t_low_irq();
    t_split();
    t_sources();
    t_capture();
    wrap_up();
  end
endmodule
